/* verilog/rcc_pkg.sv */
`default_nettype none
package rcc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int T_SOFT_RST_MS = 100;
   localparam int T_ACK_WAIT_MS = 200;
   localparam int T_RESEND_MAX_MS = 48;
   localparam int T_BO_UNIT_US = 320;
   localparam int SOFT_RST_CYC = T_SOFT_RST_MS * 1000 * CLK_MHZ;
   localparam int ACK_WAIT_CYC = T_ACK_WAIT_MS * 1000 * CLK_MHZ;
   localparam int RESEND_MAX_CYC = T_RESEND_MAX_MS * 1000 * CLK_MHZ;
   localparam int BO_UNIT_CYC = T_BO_UNIT_US * CLK_MHZ;
   localparam int TMR_W = 25;
   localparam logic [2:0] CSMA_MAX = 3'h5;
   localparam logic [1:0] BE_MAX = 2'h3;

   localparam logic [11:0] FREQ_BASE_MHZ = 12'h965;
   localparam logic [11:0] FREQ_STEP_MHZ = 12'h005;
   localparam logic [11:0] FREQ_BASE_CH = 12'h00B;
   localparam logic [31:0] CH_STD_MIN = 32'h0000000B;
   localparam logic [31:0] CH_STD_MAX = 32'h0000001A;
   localparam logic [31:0] CH_PRO_MIN = 32'h0000000C;
   localparam logic [31:0] CH_PRO_MAX = 32'h00000017;
   localparam logic [31:0] MAX16 = 32'h0000FFFF;
   localparam logic [31:0] RR_MAX = 32'h00000006;
   localparam logic [31:0] RN_MAX = 32'h00000003;
   localparam logic [15:0] SHORT_DISABLE = 16'hFFFF;
   localparam logic [31:0] SHORT_LIMIT = 32'h0000FFFF;
   localparam logic [63:0] BCAST_ADDR = 64'h000000000000FFFF;

   localparam logic [3:0] P_CH = 4'h0;
   localparam logic [3:0] P_PAN = 4'h1;
   localparam logic [3:0] P_DH = 4'h2;
   localparam logic [3:0] P_DL = 4'h3;
   localparam logic [3:0] P_MY = 4'h4;
   localparam logic [3:0] P_RR = 4'h5;
   localparam logic [3:0] P_RN = 4'h6;
   localparam logic [3:0] P_SER_HI = 4'h7;
   localparam logic [3:0] P_SER_LO = 4'h8;
   localparam int NV_WORDS = 7;

   localparam logic [2:0] CMD_READ = 3'h0;
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_PERSIST = 3'h2;
   localparam logic [2:0] CMD_DEFAULTS = 3'h3;
   localparam logic [2:0] CMD_SOFT_RESET = 3'h4;

   typedef struct packed {
      logic [7:0] ch;
      logic [15:0] pan;
      logic [31:0] dh;
      logic [31:0] dl;
      logic [15:0] my;
      logic [2:0] rr;
      logic [1:0] rn;
   } rcc_cfg_t;

   localparam rcc_cfg_t CFG_DEFAULT = '{ch: 8'h0C, pan: 16'h3332,
      dh: 32'h0, dl: 32'h0, my: 16'h0, rr: 3'h0, rn: 2'h0};
endpackage
`default_nettype wire

/* verilog/rcc_nvm_if.sv */
`default_nettype none
interface rcc_nvm_if;
   logic wr_en;
   logic [2:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctl (output wr_en, output addr, output wdata, input rdata);
   modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* verilog/rcc_nvm.sv */
`default_nettype none
module rcc_nvm
   import rcc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   rcc_nvm_if.mem nv
);
   typedef struct packed {
      logic [31:0] rdata;
   } rcc_nvm_st_t;

   rcc_nvm_st_t st;
   rcc_nvm_st_t next_st;
   // Storage survives the functional reset; ships holding factory values
   logic [31:0] mem [NV_WORDS] = '{32'(CFG_DEFAULT.ch),
      32'(CFG_DEFAULT.pan), CFG_DEFAULT.dh, CFG_DEFAULT.dl,
      32'(CFG_DEFAULT.my), 32'(CFG_DEFAULT.rr), 32'(CFG_DEFAULT.rn)};

   always_comb begin
      next_st = st;
      next_st.rdata = mem[nv.addr];
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (nv.wr_en) begin
         mem[nv.addr] <= nv.wdata;
      end
   end

   assign nv.rdata = st.rdata;
endmodule
`default_nettype wire

/* verilog/rcc_top.sv */
// Overview of operation
// R1: Parameter values are taken as hexadecimal numbers.
// R2: Persist copies settings; power-on reloads saved copy.
// R3: Host sends nothing until persist acknowledged.
// R4: Defaults command restores working set only.
// R5: Soft reset answers OK, resets 100 ms later.
// R6: Soft reset leaves command mode.
// R7: Carrier frequency follows channel number.
// R8: Channel range depends on variant; default 0xC.
// R9: Network number default 0x3332; 0xFFFF transmit-only. Here 0xFFFF gets no special handling on receive.
// R10: Exchange only with matching channel, network, address.
// R11: Short addressing when upper zero, lower small.
// R12: Own long address and broadcast always accepted. Here no frame is accepted while a soft reset is pending.
// R13: Short source 0xFFFF blocks short frames.
// R14: Factory serial halves are read-only, fixed.
// R15: Broadcast sends one or limit plus two.
// R16: Retries request ack, resend after random delay.
// R17: Retry limit 0 to 6, default zero.
// R18: Purged indirect messages are never retried.
// R19: Backoff exponent 0 to 3; zero skips first wait.
// R20: Sense channel, back off, give up after bound.
// R21: Out-of-range writes rejected, value kept.
`default_nettype none
module rcc_top
   import rcc_pkg::*;
#(
   parameter logic [31:0] SERIAL_UPPER = 32'h00A1B2C3, // Arbitrary value
   parameter logic [31:0] SERIAL_LOWER = 32'h44556677, // Arbitrary value
   parameter int RST_DLY_CYC = SOFT_RST_CYC,
   parameter int ACK_TMO_CYC = ACK_WAIT_CYC,
   parameter int RESEND_CYC = RESEND_MAX_CYC,
   parameter int BO_CYC = BO_UNIT_CYC
)(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_op_i,
   input wire logic [3:0] cmd_param_i,
   input wire logic [31:0] cmd_data_i,
   input wire logic cmd_mode_enter_i,
   input wire logic pro_variant_i,
   input wire logic tx_req_i,
   input wire logic cca_clear_i,
   input wire logic ack_i,
   input wire logic purged_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_chan_i,
   input wire logic [15:0] rx_pan_i,
   input wire logic rx_short_i,
   input wire logic [63:0] rx_dest_i,
   output logic cmd_ready_o,
   output logic resp_valid_o,
   output logic resp_err_o,
   output logic [31:0] resp_data_o,
   output logic cmd_mode_o,
   output logic soft_reset_o,
   output logic [11:0] freq_mhz_o,
   output logic [15:0] pan_number_o,
   output logic [63:0] dest_addr_o,
   output logic tx_ready_o,
   output logic tx_send_o,
   output logic tx_ack_req_o,
   output logic tx_short_o,
   output logic tx_done_o,
   output logic tx_fail_o,
   output logic rx_accept_o,
   output logic rx_reject_o
);
   typedef enum logic [1:0] {
      CTL_LOAD = 2'b00,
      CTL_IDLE = 2'b01,
      CTL_SAVE = 2'b10,
      CTL_RSTW = 2'b11
   } rcc_ctl_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_BACKOFF = 3'b001,
      TX_CCA = 3'b010,
      TX_WAIT_ACK = 3'b011,
      TX_RESEND = 3'b100
   } rcc_tx_t;

   typedef struct packed {
      rcc_ctl_t ctl;
      logic [3:0] idx;
      logic [TMR_W-1:0] rtmr;
      rcc_cfg_t cfg;
      logic pro_s1;
      logic pro_s2;
      logic cmd_mode;
      logic cmd_ready;
      logic resp_valid;
      logic resp_err;
      logic [31:0] resp_data;
      logic soft_rst;
      logic [11:0] freq;
      rcc_tx_t tx;
      logic [TMR_W-1:0] tmr;
      logic [1:0] be;
      logic [2:0] csma;
      logic [3:0] pkts;
      logic bcast;
      logic ackreq;
      logic [23:0] lfsr;
      logic tx_ready;
      logic tx_send;
      logic tx_short;
      logic tx_done;
      logic tx_fail;
      logic rx_acc;
      logic rx_rej;
   } rcc_st_t;

   localparam rcc_st_t ST_RESET = '{ctl: CTL_LOAD, tx: TX_IDLE,
      cfg: CFG_DEFAULT, lfsr: 24'hACE1B5, default: '0};

   rcc_st_t st;
   rcc_st_t next_st;
   rcc_nvm_if nv();

   function automatic logic [31:0] cfg_get(rcc_cfg_t c, logic [3:0] i);
      case (i)
         P_CH: cfg_get = 32'(c.ch);
         P_PAN: cfg_get = 32'(c.pan);
         P_DH: cfg_get = c.dh;
         P_DL: cfg_get = c.dl;
         P_MY: cfg_get = 32'(c.my);
         P_RR: cfg_get = 32'(c.rr);
         P_RN: cfg_get = 32'(c.rn);
         P_SER_HI: cfg_get = SERIAL_UPPER;
         P_SER_LO: cfg_get = SERIAL_LOWER;
         default: cfg_get = 32'h0;
      endcase
   endfunction

   function automatic rcc_cfg_t cfg_put(rcc_cfg_t c, logic [3:0] i,
                                         logic [31:0] v);
      cfg_put = c;
      case (i)
         P_CH: cfg_put.ch = v[7:0];
         P_PAN: cfg_put.pan = v[15:0];
         P_DH: cfg_put.dh = v;
         P_DL: cfg_put.dl = v;
         P_MY: cfg_put.my = v[15:0];
         P_RR: cfg_put.rr = v[2:0];
         P_RN: cfg_put.rn = v[1:0];
         default: cfg_put = c;
      endcase
   endfunction

   function automatic logic in_range(logic [3:0] i, logic [31:0] v,
                                     logic pro);
      case (i)
         P_CH: in_range = pro ? (v >= CH_PRO_MIN && v <= CH_PRO_MAX)
                              : (v >= CH_STD_MIN && v <= CH_STD_MAX); // R8
         P_PAN: in_range = v <= MAX16; // R9
         P_DH: in_range = 1'b1;
         P_DL: in_range = 1'b1;
         P_MY: in_range = v <= MAX16; // R13
         P_RR: in_range = v <= RR_MAX; // R17
         P_RN: in_range = v <= RN_MAX; // R19
         default: in_range = 1'b0; // R14
      endcase
   endfunction

   // Random number of backoff units below two to the exponent
   function automatic logic [TMR_W-1:0] backoff(logic [1:0] be,
                                                logic [23:0] r);
      logic [2:0] mask;
      mask = 3'((4'h1 << be) - 4'h1);
      backoff = TMR_W'(r[2:0] & mask) * TMR_W'(BO_CYC); // R19
   endfunction

   logic [TMR_W-1:0] resend_dly;
   logic rx_net_ok;
   logic rx_short_ok;
   logic rx_own;
   logic rx_bcast;
   logic cmd_take;

   always_comb begin
      resend_dly = TMR_W'(st.lfsr[23:2]);
      if (resend_dly > TMR_W'(RESEND_CYC)) begin
         resend_dly = TMR_W'(RESEND_CYC); // R16
      end
      rx_net_ok = rx_chan_i == st.cfg.ch && rx_pan_i == st.cfg.pan; // R10 R9
      rx_short_ok = rx_short_i && st.cfg.my != SHORT_DISABLE
         && rx_dest_i[15:0] == st.cfg.my; // R13
      rx_own = !rx_short_i && rx_dest_i == {SERIAL_UPPER, SERIAL_LOWER};
      rx_bcast = rx_dest_i == BCAST_ADDR;
      cmd_take = cmd_valid_i && st.cmd_ready;
   end

   always_comb begin
      next_st = st;
      next_st.pro_s1 = pro_variant_i;
      next_st.pro_s2 = st.pro_s1;
      next_st.lfsr = {st.lfsr[22:0],
         st.lfsr[23] ^ st.lfsr[22] ^ st.lfsr[21] ^ st.lfsr[16]};
      next_st.resp_valid = 1'b0;
      next_st.soft_rst = 1'b0;
      next_st.tx_send = 1'b0;
      next_st.tx_done = 1'b0;
      next_st.tx_fail = 1'b0;
      next_st.rx_acc = 1'b0;
      next_st.rx_rej = 1'b0;
      if (cmd_mode_enter_i) begin
         next_st.cmd_mode = 1'b1;
      end

      unique case (st.ctl)
         CTL_LOAD: begin
            if (st.idx != 4'h0) begin
               next_st.cfg = cfg_put(st.cfg, st.idx - 4'h1, nv.rdata); // R2
            end
            next_st.idx = st.idx + 4'h1;
            if (st.idx == 4'(NV_WORDS)) begin
               next_st.ctl = CTL_IDLE;
               next_st.idx = 4'h0;
            end
         end
         CTL_IDLE: begin
            if (cmd_take) begin
               next_st.resp_err = 1'b0;
               next_st.resp_data = 32'h0;
               case (cmd_op_i)
                  CMD_READ: begin
                     next_st.resp_valid = 1'b1;
                     next_st.resp_err = cmd_param_i > P_SER_LO;
                     next_st.resp_data = cfg_get(st.cfg, cmd_param_i);
                  end
                  CMD_WRITE: begin
                     next_st.resp_valid = 1'b1;
                     // Raw binary value, no decimal conversion R1
                     if (in_range(cmd_param_i, cmd_data_i, st.pro_s2)) begin
                        next_st.cfg = cfg_put(st.cfg, cmd_param_i,
                                              cmd_data_i);
                     end else begin
                        next_st.resp_err = 1'b1; // R21 R14
                     end
                  end
                  CMD_PERSIST: begin
                     next_st.ctl = CTL_SAVE; // R2
                     next_st.idx = 4'h0;
                  end
                  CMD_DEFAULTS: begin
                     next_st.resp_valid = 1'b1;
                     next_st.cfg = CFG_DEFAULT; // R4
                  end
                  CMD_SOFT_RESET: begin
                     next_st.resp_valid = 1'b1; // R5
                     next_st.ctl = CTL_RSTW;
                     next_st.rtmr = TMR_W'(RST_DLY_CYC - 1);
                  end
                  default: begin
                     next_st.resp_valid = 1'b1;
                     next_st.resp_err = 1'b1;
                  end
               endcase
            end
         end
         CTL_SAVE: begin
            // Commands are refused until the OK goes out R3
            next_st.idx = st.idx + 4'h1;
            if (st.idx == 4'(NV_WORDS - 1)) begin
               next_st.ctl = CTL_IDLE;
               next_st.idx = 4'h0;
               next_st.resp_valid = 1'b1;
               next_st.resp_err = 1'b0;
               next_st.resp_data = 32'h0;
            end
         end
         CTL_RSTW: begin
            next_st.rtmr = st.rtmr - TMR_W'(1);
            if (st.rtmr == '0) begin
               next_st = ST_RESET; // R5
               next_st.lfsr = st.lfsr;
               next_st.pro_s1 = st.pro_s1;
               next_st.pro_s2 = st.pro_s2;
               next_st.soft_rst = 1'b1;
               next_st.cmd_mode = 1'b0; // R6
            end
         end
      endcase

      if (st.ctl != CTL_RSTW) begin
         unique case (st.tx)
            TX_IDLE: begin
               if (tx_req_i && st.tx_ready) begin
                  next_st.bcast = {st.cfg.dh, st.cfg.dl} == BCAST_ADDR;
                  if (next_st.bcast) begin
                     next_st.pkts = st.cfg.rr == 3'h0 ? 4'h1
                        : 4'(st.cfg.rr) + 4'h2; // R15
                  end else begin
                     next_st.pkts = 4'(st.cfg.rr) + 4'h1; // R17
                  end
                  next_st.ackreq = !next_st.bcast && st.cfg.rr != 3'h0;
                  next_st.be = st.cfg.rn;
                  next_st.csma = 3'h0;
                  next_st.tmr = backoff(st.cfg.rn, st.lfsr); // R19
                  next_st.tx = TX_BACKOFF;
               end
            end
            TX_BACKOFF: begin
               next_st.tmr = st.tmr - TMR_W'(1);
               if (st.tmr == '0) begin
                  next_st.tx = TX_CCA;
               end
            end
            TX_CCA: begin
               if (cca_clear_i) begin
                  next_st.tx_send = 1'b1; // R20
                  next_st.pkts = st.pkts - 4'h1;
                  next_st.be = st.cfg.rn;
                  next_st.csma = 3'h0;
                  if (st.ackreq) begin
                     next_st.tx = TX_WAIT_ACK; // R16
                     next_st.tmr = TMR_W'(ACK_TMO_CYC - 1);
                  end else if (st.bcast && st.pkts != 4'h1) begin
                     next_st.tx = TX_BACKOFF; // R15
                     next_st.tmr = backoff(st.cfg.rn, st.lfsr);
                  end else begin
                     next_st.tx = TX_IDLE;
                     next_st.tx_done = 1'b1;
                  end
               end else if (st.csma == CSMA_MAX - 3'h1) begin
                  next_st.tx = TX_IDLE;
                  next_st.tx_fail = 1'b1; // R20
               end else begin
                  next_st.csma = st.csma + 3'h1;
                  next_st.be = st.be == BE_MAX ? BE_MAX : st.be + 2'h1;
                  next_st.tmr = backoff(next_st.be, st.lfsr);
                  next_st.tx = TX_BACKOFF;
               end
            end
            TX_WAIT_ACK: begin
               next_st.tmr = st.tmr - TMR_W'(1);
               if (ack_i) begin
                  next_st.tx = TX_IDLE;
                  next_st.tx_done = 1'b1;
               end else if (purged_i) begin
                  next_st.tx = TX_IDLE;
                  next_st.tx_fail = 1'b1; // R18
               end else if (st.tmr == '0) begin
                  if (st.pkts == 4'h0) begin
                     next_st.tx = TX_IDLE;
                     next_st.tx_fail = 1'b1;
                  end else begin
                     next_st.tx = TX_RESEND; // R16
                     next_st.tmr = resend_dly;
                  end
               end
            end
            TX_RESEND: begin
               next_st.tmr = st.tmr - TMR_W'(1);
               if (purged_i) begin
                  next_st.tx = TX_IDLE;
                  next_st.tx_fail = 1'b1; // R18
               end else if (st.tmr == '0) begin
                  next_st.tx = TX_BACKOFF;
                  next_st.tmr = backoff(st.cfg.rn, st.lfsr);
               end
            end
            default: next_st.tx = TX_IDLE;
         endcase

         if (rx_valid_i) begin
            next_st.rx_acc = rx_own || rx_bcast || (rx_net_ok && rx_short_ok);
            next_st.rx_rej = !next_st.rx_acc; // R12 R10
         end
      end

      next_st.freq = FREQ_BASE_MHZ
         + FREQ_STEP_MHZ * (12'(st.cfg.ch) - FREQ_BASE_CH); // R7
      next_st.tx_short = st.cfg.dh == 32'h0
         && st.cfg.dl < SHORT_LIMIT; // R11
      next_st.cmd_ready = next_st.ctl == CTL_IDLE;
      next_st.tx_ready = next_st.ctl == CTL_IDLE && next_st.tx == TX_IDLE;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign nv.wr_en = st.ctl == CTL_SAVE;
   assign nv.addr = st.idx[2:0];
   assign nv.wdata = cfg_get(st.cfg, st.idx);

   rcc_nvm u_nvm (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .nv(nv.mem)
   );

   assign cmd_ready_o = st.cmd_ready;
   assign resp_valid_o = st.resp_valid;
   assign resp_err_o = st.resp_err;
   assign resp_data_o = st.resp_data;
   assign cmd_mode_o = st.cmd_mode;
   assign soft_reset_o = st.soft_rst;
   assign freq_mhz_o = st.freq;
   assign pan_number_o = st.cfg.pan;
   assign dest_addr_o = {st.cfg.dh, st.cfg.dl};
   assign tx_ready_o = st.tx_ready;
   assign tx_send_o = st.tx_send;
   assign tx_ack_req_o = st.ackreq;
   assign tx_short_o = st.tx_short;
   assign tx_done_o = st.tx_done;
   assign tx_fail_o = st.tx_fail;
   assign rx_accept_o = st.rx_acc;
   assign rx_reject_o = st.rx_rej;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   a_write_reject: assert property ( // R21
      cmd_take && cmd_op_i == CMD_WRITE && cmd_param_i == P_RR
      && cmd_data_i > RR_MAX |=> resp_valid_o && resp_err_o
      && st.cfg.rr == $past(st.cfg.rr))
      else $error("out-of-range write not refused");
   a_chan_range: assert property ( // R8
      st.ctl == CTL_IDLE |-> st.cfg.ch >= 8'h0B && st.cfg.ch <= 8'h1A)
      else $error("channel outside range");
   a_softrst_ok: assert property ( // R5
      cmd_take && cmd_op_i == CMD_SOFT_RESET
      |=> resp_valid_o && !resp_err_o && !cmd_ready_o)
      else $error("soft reset not acknowledged at once");
   a_softrst_exit: assert property ( // R6
      soft_reset_o |-> !cmd_mode_o ##1 st.ctl == CTL_LOAD)
      else $error("command mode kept over soft reset");
   a_freq_map: assert property ( // R7
      ##1 $stable(st.cfg.ch) |=> freq_mhz_o ==
      12'h965 + 12'h005 * (12'($past(st.cfg.ch, 2)) - 12'h00B))
      else $error("frequency does not follow channel");
   a_short_block: assert property ( // R13
      rx_valid_i && rx_short_i && st.cfg.my == 16'hFFFF && !rx_bcast
      && st.ctl != CTL_RSTW |=> rx_reject_o && !rx_accept_o)
      else $error("short frame accepted while disabled");
   a_own_accept: assert property ( // R12
      rx_valid_i && (rx_own || rx_bcast) && st.ctl != CTL_RSTW
      |=> rx_accept_o)
      else $error("own or broadcast frame rejected");
   a_bcast_noack: assert property ( // R15
      tx_send_o && st.bcast |-> !tx_ack_req_o)
      else $error("broadcast requests acknowledgement");
   a_retry_range: assert property ( // R17
      st.cfg.rr <= 3'h6)
      else $error("retry limit above six");
   a_persist_busy: assert property ( // R2
      st.ctl == CTL_IDLE ##1 st.ctl == CTL_SAVE
      |-> !cmd_ready_o [*7] ##1 resp_valid_o)
      else $error("persist sequence length wrong");
endmodule
`default_nettype wire

/* bench/rcc_radio_model.sv */
`default_nettype none
module rcc_radio_model (
   input wire logic mclk_i,
   input wire logic tx_send_i,
   input wire logic ack_on_i,
   input wire logic busy_i,
   output logic cca_clear_o,
   output logic ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic ack_q = 1'b0;
   assign cca_clear_o = !busy_i;
   assign ack_o = ack_q;
   // Peer answers a few cycles after each packet when enabled
   always @(posedge mclk_i) begin
      ack_q <= 1'b0;
      if (tx_send_i && ack_on_i) begin
         cnt <= 6;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         ack_q <= (cnt == 1);
      end
   end
endmodule
`default_nettype wire

/* bench/radio_config_command_set_tb.sv */
`default_nettype none
module radio_config_command_set_tb import rcc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SU = 32'h0BADF00D; // Arbitrary value
   localparam logic [31:0] SL = 32'h13572468; // Arbitrary value
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cv = 1'b0, cme = 1'b0, pro = 1'b0, txr = 1'b0, busy = 1'b0;
   logic acken = 1'b0, rxv = 1'b0, rxs = 1'b0, prg = 1'b0;
   logic [15:0] pano;
   logic [63:0] dsto;
   logic [2:0] cop = 3'h0;
   logic [3:0] cpar = 4'h0;
   logic [31:0] cdat = 32'h0, r = 32'h26637FA5;
   logic [7:0] rxc = 8'h0;
   logic [15:0] rxp = 16'h0;
   logic [63:0] rxd = 64'h0;
   logic rdy, rv, rerr, cmo, srst, txrdy, txs, txa, txsh, txd, txf;
   logic rxa, rxj, cca, ack;
   logic [31:0] rdat;
   logic [11:0] frq;
   logic [31:0] e [9];
   logic [31:0] s [9];
   logic [35:0] cp [12];
   int failures = 0;
   int comparisons = 0;
   int n;
   rcc_top #(.SERIAL_UPPER(SU), .SERIAL_LOWER(SL), .RST_DLY_CYC(50),
      .ACK_TMO_CYC(40), .RESEND_CYC(20), .BO_CYC(4)) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cv),
      .cmd_op_i(cop), .cmd_param_i(cpar), .cmd_data_i(cdat),
      .cmd_mode_enter_i(cme), .pro_variant_i(pro), .tx_req_i(txr),
      .cca_clear_i(cca), .ack_i(ack), .purged_i(prg),
      .rx_valid_i(rxv), .rx_chan_i(rxc), .rx_pan_i(rxp),
      .rx_short_i(rxs), .rx_dest_i(rxd), .cmd_ready_o(rdy),
      .resp_valid_o(rv), .resp_err_o(rerr), .resp_data_o(rdat),
      .cmd_mode_o(cmo), .soft_reset_o(srst), .freq_mhz_o(frq),
      .pan_number_o(pano), .dest_addr_o(dsto), .tx_ready_o(txrdy),
      .tx_send_o(txs), .tx_ack_req_o(txa), .tx_short_o(txsh),
      .tx_done_o(txd), .tx_fail_o(txf), .rx_accept_o(rxa),
      .rx_reject_o(rxj));
   rcc_radio_model peer (.mclk_i(mclk_i), .tx_send_i(txs),
      .ack_on_i(acken), .busy_i(busy), .cca_clear_o(cca), .ack_o(ack));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] nx(logic [31:0] x);
      nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic ok(logic [3:0] p, logic [31:0] d);
      case (p)
         4'h0: ok = pro ? (d >= 32'hC && d <= 32'h17) :
            (d >= 32'hB && d <= 32'h1A);
         4'h1, 4'h4: ok = d <= 32'hFFFF;
         4'h2, 4'h3: ok = 1'b1;
         4'h5: ok = d <= 32'h6;
         4'h6: ok = d <= 32'h3;
         default: ok = 1'b0;
      endcase
   endfunction
   task automatic step();
      @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(string nm, logic [63:0] x, logic [63:0] g);
      comparisons++;
      if (x !== g) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmd(logic [2:0] op, logic [3:0] p, logic [31:0] d);
      int k;
      k = 0;
      while (rdy !== 1'b1 && k < 300) begin
         step();
         k++;
      end
      @(posedge mclk_i);
      cv <= 1'b1;
      cop <= op;
      cpar <= p;
      cdat <= d;
      @(posedge mclk_i);
      cv <= 1'b0;
      #1;
      k = 0;
      while (rv !== 1'b1 && k < 12) begin
         step();
         k++;
      end
      chk("resp_valid", 1, rv);
   endtask
   task automatic rd(logic [3:0] p);
      cmd(CMD_READ, p, 32'h0);
      chk("read_err", 0, rerr);
      chk("read_data", e[p], rdat);
      chk("freq", 12'h965 + (e[0][11:0] - 12'h00B) * 12'h005, frq);
      chk("tx_short", e[2] == 0 && e[3] < 32'hFFFF, txsh);
      chk("pan", e[1], pano);
      chk("dest", {e[2], e[3]}, dsto);
   endtask
   task automatic wr(logic [3:0] p, logic [31:0] d);
      logic g;
      g = ok(p, d);
      cmd(CMD_WRITE, p, d);
      chk("write_err", !g, rerr);
      if (g) e[p] = d;
      rd(p);
   endtask
   task automatic rx(logic [7:0] c, logic [15:0] pn, logic [63:0] dd,
         logic sh, logic x);
      @(posedge mclk_i);
      rxv <= 1'b1;
      rxc <= c;
      rxp <= pn;
      rxs <= sh;
      rxd <= dd;
      @(posedge mclk_i);
      rxv <= 1'b0;
      #1;
      chk("rx_accept", x, rxa);
      chk("rx_reject", !x, rxj);
   endtask
   task automatic tx(logic ak, logic bz, int np, logic xa, logic xf,
         logic pg);
      int c;
      logic a;
      c = 0;
      a = 0;
      @(posedge mclk_i);
      acken <= ak;
      busy <= bz;
      prg <= pg;
      txr <= 1'b1;
      @(posedge mclk_i);
      txr <= 1'b0;
      #1;
      for (int k = 0; k < 3000 && txd !== 1'b1 && txf !== 1'b1; k++) begin
         step();
         c += (txs === 1'b1);
         a |= (txs === 1'b1) & txa;
      end
      chk("tx_packets", np, c);
      chk("tx_ack_req", xa, a);
      chk("tx_fail", xf, txf);
      chk("tx_ready", 1, txrdy);
   endtask
   initial begin
      repeat (60000) @(posedge mclk_i);
      failures++;
      $display("Error watchdog expired");
      end_sim();
   end
   initial begin
      e = '{32'hC, 32'h3332, 0, 0, 0, 0, 0, SU, SL};
      cp = '{{4'h0, 32'hA}, {4'h0, 32'hB}, {4'h0, 32'h1A}, {4'h0, 32'h1B},
         {4'h1, 32'h10000}, {4'h1, 32'hFFFF}, {4'h5, 32'h6}, {4'h5, 32'h7},
         {4'h6, 32'h3}, {4'h6, 32'h4}, {4'h7, 32'h1}, {4'h8, 32'h2}};
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int p = 0; p < 9; p++) rd(p[3:0]);
      cmd(CMD_READ, 4'h9, 32'h0);
      chk("bad_index", 1, rerr);
      $display("test defaults done");
      foreach (cp[i]) wr(cp[i][35:32], cp[i][31:0]);
      pro <= 1'b1;
      repeat (4) step();
      wr(4'h0, 32'hB);
      wr(4'h0, 32'h17);
      wr(4'h0, 32'h18);
      pro <= 1'b0;
      repeat (4) step();
      for (int i = 0; i < 40; i++) begin
         r = nx(r);
         n = r[3:0] % 9;
         r = nx(r);
         wr(n[3:0], r[8] ? {27'h0, r[31:27]} : r);
      end
      $display("test writes done");
      s = e;
      cmd(CMD_PERSIST, 4'h0, 32'h0);
      chk("persist_err", 0, rerr);
      cmd(CMD_DEFAULTS, 4'h0, 32'h0);
      e = '{32'hC, 32'h3332, 0, 0, 0, 0, 0, SU, SL};
      for (int p = 0; p < 7; p++) rd(p[3:0]);
      @(posedge mclk_i);
      cme <= 1'b1;
      @(posedge mclk_i);
      cme <= 1'b0;
      step();
      chk("cmd_mode", 1, cmo);
      cmd(CMD_SOFT_RESET, 4'h0, 32'h0);
      chk("reset_err", 0, rerr);
      for (n = 0; n < 100 && srst !== 1'b1; n++) step();
      chk("reset_delay", 1, n >= 48 && n <= 52);
      step();
      chk("cmd_mode", 0, cmo);
      e = s;
      for (int p = 0; p < 7; p++) rd(p[3:0]);
      $display("test persist done");
      wr(4'h0, 32'hF);
      wr(4'h1, 32'h1234);
      wr(4'h4, 32'h55);
      rx(8'h11, 16'h0, {SU, SL}, 1'b0, 1'b1);
      rx(8'h11, 16'h0, 64'hFFFF, 1'b1, 1'b1);
      rx(8'hF, 16'h1234, 64'h55, 1'b1, 1'b1);
      rx(8'hF, 16'h1235, 64'h55, 1'b1, 1'b0);
      rx(8'h10, 16'h1234, 64'h55, 1'b1, 1'b0);
      rx(8'hF, 16'hFFFF, 64'h55, 1'b1, 1'b0);
      wr(4'h4, 32'hFFFF);
      rx(8'hF, 16'h1234, 64'h1_0000_FFFF, 1'b1, 1'b0);
      $display("test receive done");
      wr(4'h2, 32'h0);
      wr(4'h3, 32'hFFFF);
      wr(4'h5, 32'h0);
      tx(1'b0, 1'b0, 1, 1'b0, 1'b0, 1'b0);
      wr(4'h5, 32'h3);
      tx(1'b0, 1'b0, 5, 1'b0, 1'b0, 1'b0);
      wr(4'h6, 32'h2);
      wr(4'h3, 32'h1234);
      wr(4'h5, 32'h2);
      tx(1'b0, 1'b0, 3, 1'b1, 1'b1, 1'b0);
      tx(1'b1, 1'b0, 1, 1'b1, 1'b0, 1'b0);
      wr(4'h5, 32'h6);
      tx(1'b0, 1'b0, 7, 1'b1, 1'b1, 1'b0);
      wr(4'h6, 32'h0);
      tx(1'b0, 1'b1, 0, 1'b0, 1'b1, 1'b0);
      tx(1'b0, 1'b0, 1, 1'b1, 1'b1, 1'b1);
      $display("test transmit done");
      end_sim();
   end
endmodule
`default_nettype wire
